// *** hw/pit_irq_ctrl.sv ***
// pit_irq_ctrl: sticky event status, mask and one level interrupt
// assumes event pulses and write strobes come from the same clock
`timescale 1ns/1ps
`default_nettype none
module pit_irq_ctrl #(
    parameter int INT_W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [INT_W-1:0] event_set,
    input wire logic clear_wr,
    input wire logic mask_wr,
    input wire logic [INT_W-1:0] wr_bits,
    output logic [INT_W-1:0] status,
    output logic [INT_W-1:0] mask,
    output logic irq
);

    logic [INT_W-1:0] next_status;

    // write one clears, a same-cycle event wins
    always_comb begin
        next_status = status;
        if (clear_wr) begin
            next_status = next_status & ~wr_bits;
        end
        next_status = next_status | event_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (mask_wr) begin
            mask <= wr_bits;
        end
    end

    // level request while an enabled bit is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & (mask_wr ? wr_bits : mask));
        end
    end

endmodule
`default_nettype wire

// *** hw/pit_prescaler.sv ***
// pit_prescaler: reloadable cycle divider producing decrement pulses
// assumes scale is stable or that a reload is requested when it changes
`timescale 1ns/1ps
`default_nettype none
module pit_prescaler #(
    parameter int SCALE_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic reload,
    input wire logic [SCALE_W-1:0] scale,
    output logic tick,
    output logic [SCALE_W-1:0] remain
);

    logic expire;

    assign expire = run && (remain == '0);

    // down count, reload from scale on expiry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (reload || expire) begin
            remain <= scale;
        end else if (run) begin
            remain <= remain - 1'b1;
        end
    end

    // one decrement pulse per expiry, none when a reload comes in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= expire && !reload;
        end
    end

endmodule
`default_nettype wire

// *** hw/pit_top.sv ***
// pit_top: prescaled 16-bit interval timer with register port and interrupt
// assumes a single clock; bus strobes come from logic on that clock
// assumes software never raises both strobes in one cycle
// disabling the timer drops a divider tick still in flight
`timescale 1ns/1ps
`default_nettype none
module pit_top
    import pit_pkg::*;
#(
    parameter int COUNT_WIDTH = pit_pkg::COUNT_W,
    parameter int SCALE_WIDTH = pit_pkg::SCALE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pit_pkg::ADDR_W-1:0] addr,
    input wire logic [pit_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [pit_pkg::DATA_W-1:0] rd_data,
    output logic timer_irq,
    output logic timer_event
);

    import pit_pkg::*;

    // register state
    logic [COUNT_WIDTH-1:0] timer_count;
    logic [SCALE_WIDTH-1:0] timer_scale;
    logic [COUNT_WIDTH-1:0] timer_period;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] expiry_count;

    // decoded access
    pit_sel_t wr_sel;
    pit_sel_t rd_sel;
    logic wr_count;
    logic wr_scale;
    logic wr_period;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_expiry;

    // timer datapath
    logic run;
    logic tick;
    logic step;
    logic wr_enable;
    logic wr_restart;
    logic reload_pre;
    logic at_zero;
    logic zero_hit;
    logic reload_count;
    logic clear_zero;
    logic overrun;
    logic [SCALE_WIDTH-1:0] pre_remain;
    logic [COUNT_WIDTH-1:0] next_count;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_events;
    logic [DATA_W-1:0] next_rd_data;

    // read words, unused bits zero
    logic [DATA_W-1:0] count_word;
    logic [DATA_W-1:0] scale_word;
    logic [DATA_W-1:0] period_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] mask_word;
    logic [DATA_W-1:0] state_word;

    // address to register selector
    function automatic pit_sel_t decode(input logic [ADDR_W-1:0] a);
        pit_sel_t s;
        s = PIT_SEL_NONE;
        unique case (a)
            OFS_TIMER_COUNT: begin
                s = PIT_SEL_COUNT;
            end
            OFS_TIMER_SCALE: begin
                s = PIT_SEL_SCALE;
            end
            OFS_TIMER_PERIOD: begin
                s = PIT_SEL_PERIOD;
            end
            OFS_CTRL: begin
                s = PIT_SEL_CTRL;
            end
            OFS_INT_STATUS: begin
                s = PIT_SEL_STATUS;
            end
            OFS_INT_MASK: begin
                s = PIT_SEL_MASK;
            end
            OFS_STATE: begin
                s = PIT_SEL_STATE;
            end
            OFS_EXPIRY_COUNT: begin
                s = PIT_SEL_EXPIRY;
            end
            default: begin
                s = PIT_SEL_NONE;
            end
        endcase
        return s;
    endfunction

    // widen a field into the data word
    function automatic logic [DATA_W-1:0] widen16(input logic [COUNT_WIDTH-1:0] v);
        logic [DATA_W-1:0] w;
        w = '0;
        w[COUNT_WIDTH-1:0] = v;
        return w;
    endfunction

    function automatic logic [DATA_W-1:0] widen8(input logic [SCALE_WIDTH-1:0] v);
        logic [DATA_W-1:0] w;
        w = '0;
        w[SCALE_WIDTH-1:0] = v;
        return w;
    endfunction

    function automatic logic [DATA_W-1:0] widen_int(input logic [INT_W-1:0] v);
        logic [DATA_W-1:0] w;
        w = '0;
        w[INT_W-1:0] = v;
        return w;
    endfunction

    // running flag and divider remainder in one word
    function automatic logic [DATA_W-1:0] pack_state(input logic r,
        input logic [SCALE_WIDTH-1:0] q);
        logic [DATA_W-1:0] w;
        w = '0;
        w[STATE_RUN_BIT] = r;
        w[STATE_PRESCALE_LSB +: SCALE_WIDTH] = q;
        return w;
    endfunction

    assign wr_sel = wr_en ? decode(addr) : PIT_SEL_NONE;
    assign rd_sel = rd_en ? decode(addr) : PIT_SEL_NONE;

    assign wr_count = (wr_sel == PIT_SEL_COUNT);
    assign wr_scale = (wr_sel == PIT_SEL_SCALE);
    assign wr_period = (wr_sel == PIT_SEL_PERIOD);
    assign wr_ctrl = (wr_sel == PIT_SEL_CTRL);
    assign wr_status = (wr_sel == PIT_SEL_STATUS);
    assign wr_mask = (wr_sel == PIT_SEL_MASK);
    assign wr_expiry = (wr_sel == PIT_SEL_EXPIRY);

    // free running from the enable bit, no processor handshake
    assign run = ctrl[CTRL_ENABLE_BIT];

    // control fields as written
    assign wr_enable = wr_data[CTRL_ENABLE_BIT];
    assign wr_restart = wr_data[CTRL_RESTART_BIT];

    // restart the divider on new scale, restart request or enable edge
    assign reload_pre = wr_scale
        || (wr_ctrl && wr_restart)
        || (wr_ctrl && wr_enable && !run);

    // a tick still in flight when disabled is dropped
    assign step = tick && run;

    assign at_zero = (timer_count == '0);

    // reload due on this decrement pulse
    assign reload_count = step && at_zero;

    // counter found at zero on a decrement pulse, no count write that cycle
    assign zero_hit = reload_count && !wr_count;

    // zero bit being cleared by this write
    assign clear_zero = wr_status && wr_data[INT_ZERO_BIT];

    // a zero expiry while the previous one is still pending
    assign overrun = zero_hit && int_status[INT_ZERO_BIT] && !clear_zero;

    always_comb begin
        int_events = '0;
        int_events[INT_ZERO_BIT] = zero_hit;
        int_events[INT_OVERRUN_BIT] = overrun;
    end

    // control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl <= '0;
            ctrl[CTRL_ENABLE_BIT] <= wr_enable;
        end
    end

    // scale register steering the divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_scale <= RST_TIMER_SCALE;
        end else if (wr_scale) begin
            timer_scale <= wr_data[SCALE_WIDTH-1:0];
        end
    end

    // period register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_period <= RST_TIMER_PERIOD;
        end else if (wr_period) begin
            timer_period <= wr_data[COUNT_WIDTH-1:0];
        end
    end

    // count next value: software load beats a decrement
    always_comb begin
        next_count = timer_count;
        if (wr_count) begin
            next_count = wr_data[COUNT_WIDTH-1:0];
        end else if (step) begin
            if (at_zero) begin
                next_count = timer_period;
            end else begin
                next_count = timer_count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count <= RST_TIMER_COUNT;
        end else begin
            timer_count <= next_count;
        end
    end

    // number of reloads since reset or the last write, wraps; a clear loses no reload
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expiry_count <= '0;
        end else if (wr_expiry) begin
            expiry_count <= {{(DATA_W-1){1'b0}}, zero_hit};
        end else if (zero_hit) begin
            expiry_count <= expiry_count + 1'b1;
        end
    end

    // dedicated timer event pulse, apart from other sources
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_event <= 1'b0;
        end else begin
            timer_event <= zero_hit;
        end
    end

    // read words, unused bits zero
    assign count_word = widen16(timer_count);
    assign scale_word = widen8(timer_scale);
    assign period_word = widen16(timer_period);
    assign status_word = widen_int(int_status);
    assign mask_word = widen_int(int_mask);
    assign state_word = pack_state(run, pre_remain);

    // read multiplexer
    always_comb begin
        next_rd_data = '0;
        unique case (rd_sel)
            PIT_SEL_COUNT: begin
                next_rd_data = count_word;
            end
            PIT_SEL_SCALE: begin
                next_rd_data = scale_word;
            end
            PIT_SEL_PERIOD: begin
                next_rd_data = period_word;
            end
            PIT_SEL_CTRL: begin
                next_rd_data = ctrl;
            end
            PIT_SEL_STATUS: begin
                next_rd_data = status_word;
            end
            PIT_SEL_MASK: begin
                next_rd_data = mask_word;
            end
            PIT_SEL_STATE: begin
                next_rd_data = state_word;
            end
            PIT_SEL_EXPIRY: begin
                next_rd_data = expiry_count;
            end
            PIT_SEL_NONE: begin
                next_rd_data = '0;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // cycle divider
    pit_prescaler #(
        .SCALE_W(SCALE_WIDTH)
    ) u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .run(run),
        .reload(reload_pre),
        .scale(timer_scale),
        .tick(tick),
        .remain(pre_remain)
    );

    // sticky status, mask and interrupt line
    pit_irq_ctrl #(
        .INT_W(INT_W)
    ) u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .event_set(int_events),
        .clear_wr(wr_status),
        .mask_wr(wr_mask),
        .wr_bits(wr_data[INT_W-1:0]),
        .status(int_status),
        .mask(int_mask),
        .irq(timer_irq)
    );

endmodule
`default_nettype wire

// *** pkg/pit_pkg.sv ***
// pit_pkg: constants shared by the prescaled interval timer
// assumes a single 20 MHz clock and the plain register port of pit_top
package pit_pkg;

    // clock
    localparam int CLK_FREQ_HZ = 20_000_000;

    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int COUNT_W = 16;
    localparam int SCALE_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h00;
    localparam logic [7:0] OFS_TIMER_SCALE = 8'h04;
    localparam logic [7:0] OFS_TIMER_PERIOD = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;
    localparam logic [7:0] OFS_EXPIRY_COUNT = 8'h1C;

    // control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;

    // interrupt status fields
    localparam int INT_W = 2;
    localparam int INT_ZERO_BIT = 0;
    localparam int INT_OVERRUN_BIT = 1;

    // state register fields
    localparam int STATE_RUN_BIT = 0;
    localparam int STATE_PRESCALE_LSB = 8;

    // reset values
    localparam logic [15:0] RST_TIMER_COUNT = 16'h0000;
    localparam logic [7:0] RST_TIMER_SCALE = 8'h00;
    localparam logic [15:0] RST_TIMER_PERIOD = 16'h0000;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [1:0] RST_INT_MASK = 2'h0;

    // register selector
    typedef enum {
        PIT_SEL_NONE,
        PIT_SEL_COUNT,
        PIT_SEL_SCALE,
        PIT_SEL_PERIOD,
        PIT_SEL_CTRL,
        PIT_SEL_STATUS,
        PIT_SEL_MASK,
        PIT_SEL_STATE,
        PIT_SEL_EXPIRY
    } pit_sel_t;

endpackage

// *** tb/pit_top_sva.sv ***
// pit_top_sva: port-level checks for the interval timer
// assumes one clock domain and the plain register port of pit_top
`timescale 1ns/1ps
`default_nettype none
module pit_top_sva
    import pit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pit_pkg::ADDR_W-1:0] addr,
    input wire logic [pit_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [pit_pkg::DATA_W-1:0] rd_data,
    input wire logic timer_irq,
    input wire logic timer_event
);
    logic written;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            written <= 1'b0;
        end else if (wr_en) begin
            written <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_rd_idle_zero: assert property (!rd_en |=> rd_data == 16'h0000)
        else $error("read data not zero after idle cycle");
    chk_rd_unmapped: assert property (rd_en && (addr[1:0] != 2'h0 || addr > OFS_EXPIRY_COUNT)
        |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    chk_scale_width: assert property (rd_en && addr == OFS_TIMER_SCALE
        |=> rd_data[15:8] == 8'h00)
        else $error("scale upper bits not zero");
    chk_ctrl_readback: assert property (rd_en && addr == OFS_CTRL |=> rd_data[15:1] == 15'h0000)
        else $error("control upper bits not zero");
    chk_period_readback: assert property ((wr_en && addr == OFS_TIMER_PERIOD) ##1 !wr_en
        ##1 (rd_en && addr == OFS_TIMER_PERIOD) |=> rd_data == $past(wr_data, 3))
        else $error("period readback wrong");
    chk_irq_rise: assert property ($rose(timer_irq)
        |-> timer_event || $past(timer_event) || $past(wr_en) || $past(wr_en, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(timer_irq) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("interrupt fell without write");
    chk_quiet_idle: assert property (!written |-> !timer_event)
        else $error("event before any setup");
endmodule
bind pit_top pit_top_sva pit_top_sva_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer_irq(timer_irq), .timer_event(timer_event));
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: self-checking bench for pit_top
// assumes the register map and timing of pit_pkg, 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pit_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic timer_irq;
    logic timer_event;
    int error_cnt = 0;
    int comparisons = 0;
    logic [DATA_W-1:0] d0;
    logic [DATA_W-1:0] d1;
    logic [7:0] ofs[4] = '{OFS_TIMER_COUNT, OFS_TIMER_SCALE, OFS_TIMER_PERIOD, OFS_INT_MASK};
    logic [15:0] msk[4] = '{16'hFFFF, 16'h00FF, 16'hFFFF, 16'h0003};
    int s;
    int p;
    int n;
    int m;
    always #25 clk = ~clk;
    pit_top pit_top_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer_irq(timer_irq),
        .timer_event(timer_event));
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
    // cycles from call to next event pulse
    task automatic wait_ev(output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
            if (cyc > 5000) begin
                error_cnt++;
                stop_test();
            end
        end while (timer_event !== 1'b1);
    endtask
    function automatic int interval(input int sc, input int pe);
        return (pe + 1) * (sc + 1);
    endfunction
    // divider remainder t cycles after its reload from sc
    function automatic int pre_left(input int sc, input int t);
        return sc - (t % (sc + 1));
    endfunction
    initial begin
        void'($urandom(32'h56ce69fe));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, then unmapped places
        for (int i = 0; i < 10; i++) begin
            rd(8'(i * 4), d0);
            cmp(d0, 16'h0000);
        end
        rd(8'h03, d0);
        cmp(d0, 16'h0000);
        // random readback, unmapped write in between
        for (int i = 0; i < 16; i++) begin
            d0 = 16'($urandom);
            wr(ofs[i % 4], d0);
            wr(8'h22, ~d0);
            rd(ofs[i % 4], d1);
            cmp(d1, d0 & msk[i % 4]);
        end
        // decrement spacing, widest scale first
        for (int j = 0; j < 4; j++) begin
            s = (j == 0) ? 255 : $urandom_range(5);
            m = $urandom_range(6, 3);
            n = m * (s + 1);
            wr(OFS_TIMER_SCALE, 16'(s));
            wr(OFS_TIMER_COUNT, 16'h8000);
            wr(OFS_CTRL, 16'h0001);
            rd(OFS_TIMER_COUNT, d0);
            repeat (n - 2) @(posedge clk);
            rd(OFS_TIMER_COUNT, d1);
            cmp(d0 - d1, 16'(m));
            rd(OFS_STATE, d0);
            cmp(d0, 16'h0001 | 16'(pre_left(s, n + 3) << 8));
            wr(OFS_CTRL, 16'h0003);
            rd(OFS_STATE, d0);
            cmp(d0, 16'h0001 | 16'(pre_left(s, 1) << 8));
            rd(OFS_CTRL, d0);
            cmp(d0, 16'h0001);
            wr(OFS_CTRL, 16'h0000);
        end
        // reload interval, status, mask and clear
        for (int j = 0; j < 6; j++) begin
            s = (j == 0) ? 0 : $urandom_range(3);
            p = (j == 0) ? 0 : $urandom_range(6);
            wr(OFS_TIMER_SCALE, 16'(s));
            wr(OFS_TIMER_PERIOD, 16'(p));
            rd(OFS_TIMER_PERIOD, d1);
            cmp(d1, 16'(p));
            wr(OFS_TIMER_COUNT, 16'h0000);
            wr(OFS_EXPIRY_COUNT, 16'h0000);
            wr(OFS_INT_MASK, 16'(j % 2));
            wr(OFS_CTRL, 16'h0001);
            wait_ev(n);
            wait_ev(n);
            cmp(16'(n), 16'(interval(s, p)));
            cmp({15'h0000, timer_irq}, 16'(j % 2));
            rd(OFS_EXPIRY_COUNT, d0);
            cmp(d0, 16'(2 + ((interval(s, p) == 1) ? 1 : 0)));
            rd(OFS_INT_STATUS, d0);
            cmp(d0, 16'h0003);
            wr(OFS_CTRL, 16'h0000);
            repeat (2) @(posedge clk);
            wr(OFS_INT_STATUS, 16'h0003);
            rd(OFS_INT_STATUS, d0);
            cmp(d0, 16'h0000);
            cmp({15'h0000, timer_irq}, 16'h0000);
        end
        stop_test();
    end
endmodule
`default_nettype wire
